// ===== hw/ecpu_cfg.svh
`ifndef ECPU_CFG_SVH
`define ECPU_CFG_SVH
// ==========================================================
// counter and data register layout
`define ECPU_CNT_W       32
`define ECPU_STAMP_N     4
`define ECPU_PTR_W       2
`define ECPU_PTR_RESET   2'h0
`define ECPU_PTR_STEP    2'h1
// ==========================================================
// shared data register roles
`define ECPU_IDX_PRD     0
`define ECPU_IDX_CMP     1
`define ECPU_IDX_SPRD    2
`define ECPU_IDX_SCMP    3
// ==========================================================
// timing of the pwm output
`define ECPU_CLK_NS      25
`define ECPU_PWM_MIN_NS  20
`define ECPU_PWM_MIN_CYC \
  (((`ECPU_PWM_MIN_NS + `ECPU_CLK_NS - 1) / `ECPU_CLK_NS) < 1 ? 1 : \
   ((`ECPU_PWM_MIN_NS + `ECPU_CLK_NS - 1) / `ECPU_CLK_NS))
`endif

// ===== hw/ecpu_pkg.sv
`include "ecpu_cfg.svh"
package ecpu_pkg;
  // ==========================================================
  // operating mode, one-hot
  typedef enum logic [1:0] {
    ECPU_MODE_CAPTURE = 2'h1,
    ECPU_MODE_PWM     = 2'h2
  } ecpu_mode_t;

  // ==========================================================
  // sticky event flags
  typedef struct packed {
    logic capture;
    logic overflow;
    logic period;
    logic compare;
  } ecpu_flags_t;

  // ==========================================================
  // shadow write request
  typedef struct packed {
    logic                   write;
    logic [`ECPU_CNT_W-1:0] period;
    logic [`ECPU_CNT_W-1:0] compare;
  } ecpu_shadow_t;
endpackage

// ===== hw/ecpu_rise_detect.sv
module ecpu_rise_detect (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic enable,
  input  wire logic level_in,
  output logic      rise
);
  logic last_reg;

  // a level that rose while the clock is gated gives its edge once enable returns, as with a stopped clock
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      last_reg <= 1'b0;
    end else if (enable) begin
      last_reg <= level_in;
    end
  end

  assign rise = enable & level_in & ~last_reg;
endmodule

// ===== hw/ecpu_event_capture_channel.sv
// How it works
// R1 - in capture mode an input rising edge stores the counter value.
// R2 - capture_or_pwm_select picks capture (low) or pwm (high) operation.
// R3 - in pwm operation the counter counts upward only, as the time base.
// R4 - in pwm operation data register one is the period, two the compare.
// R5 - in pwm operation data registers three and four shadow those two.
// R6 - one set of four data registers serves both capture and pwm operation.
// R7 - sync in loads the phase value and sync out pulses on sync, wrap or overflow.
// R8 - capture, pwm and counter events set flags merged onto one interrupt.
// R9 - counter, mode, pointer, data and pwm state advance only while clock_enable is high; flags, interrupt and sync out update every clock.
// R10 - pwm count wraps to zero at the period; high at wrap, low at compare.
// R11 - shadow values reach the active registers only at the counter wrap.
`include "ecpu_cfg.svh"
module ecpu_event_capture_channel
  import ecpu_pkg::*;
#(
  parameter int CNT_W = `ECPU_CNT_W
) (
  input  wire logic              clk_sys,
  input  wire logic              reset,
  input  wire logic              clock_enable,
  input  wire logic              capture_or_pwm_select,
  input  wire logic              event_in,
  input  wire logic              counter_sync_in,
  input  wire logic              sync_load_enable,
  input  wire logic [CNT_W-1:0]  sync_phase,
  input  wire ecpu_shadow_t      shadow_req,
  input  wire ecpu_flags_t       flag_clear,
  input  wire ecpu_flags_t       flag_enable,
  output logic [CNT_W-1:0]       counter_value,
  output logic [CNT_W-1:0]       period_or_stamp_one,
  output logic [CNT_W-1:0]       compare_or_stamp_two,
  output logic [CNT_W-1:0]       shadow_period_stamp_three,
  output logic [CNT_W-1:0]       shadow_compare_stamp_four,
  output logic                   auxiliary_pwm_output,
  output logic                   counter_sync_out,
  output logic                   channel_interrupt,
  output ecpu_flags_t            flags_out,
  output ecpu_mode_t             mode_out
);
  // ==========================================================
  // state
  logic [CNT_W-1:0]            stamp_reg [`ECPU_STAMP_N];
  logic [CNT_W-1:0]            counter_reg;
  logic [`ECPU_PTR_W-1:0]      ptr_reg;
  ecpu_mode_t                  mode_reg;
  ecpu_flags_t                 flags_reg;
  ecpu_flags_t                 flags_next;
  ecpu_flags_t                 flags_set;
  logic                        pwm_reg;
  logic                        sync_out_reg;
  logic                        irq_reg;
  logic                        event_rise;
  logic                        sync_rise;
  logic                        is_pwm;
  logic                        wrap;
  logic                        cmp_hit;
  logic                        overflow;
  logic                        capture_fire;
  logic                        sync_load;

  function automatic logic slot_hit(input logic [`ECPU_PTR_W-1:0] p,
                                    input int k);
    slot_hit = (p == k[`ECPU_PTR_W-1:0]);
  endfunction

  // ==========================================================
  // input edges
  ecpu_rise_detect u_event_rise (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .enable   (clock_enable),
    .level_in (event_in),
    .rise     (event_rise)
  );

  ecpu_rise_detect u_sync_rise (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .enable   (clock_enable),
    .level_in (counter_sync_in),
    .rise     (sync_rise)
  );

  // ==========================================================
  // decode
  assign is_pwm       = (mode_reg == ECPU_MODE_PWM);
  assign wrap         = clock_enable & is_pwm &
                        (counter_reg >= stamp_reg[`ECPU_IDX_PRD]); // R10
  assign cmp_hit      = clock_enable & is_pwm &
                        (counter_reg == stamp_reg[`ECPU_IDX_CMP]); // R4
  assign overflow     = clock_enable & ~is_pwm & (&counter_reg);
  assign capture_fire = event_rise & ~is_pwm; // R1
  assign sync_load    = sync_rise & sync_load_enable; // R7

  // ==========================================================
  // mode select
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      mode_reg <= ECPU_MODE_CAPTURE;
    end else if (clock_enable) begin // R9
      mode_reg <= capture_or_pwm_select ? ECPU_MODE_PWM
                                        : ECPU_MODE_CAPTURE; // R2
    end
  end

  // ==========================================================
  // counter
  // a sync load outranks the wrap so chained units realign at once
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      counter_reg <= '0;
    end else if (clock_enable) begin // R9
      if (sync_load) begin
        counter_reg <= sync_phase; // R7
      end else if (wrap) begin
        counter_reg <= '0; // R10
      end else begin
        counter_reg <= counter_reg + CNT_W'(1); // R3
      end
    end
  end

  // ==========================================================
  // capture pointer, restarts whenever pwm operation is in force
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ptr_reg <= `ECPU_PTR_RESET;
    end else if (clock_enable) begin
      if (is_pwm) begin
        ptr_reg <= `ECPU_PTR_RESET;
      end else if (capture_fire) begin
        ptr_reg <= ptr_reg + `ECPU_PTR_STEP; // R1
      end
    end
  end

  // ==========================================================
  // shared data registers
  for (genvar k = 0; k < `ECPU_STAMP_N; k++) begin : g_stamp
    always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
        stamp_reg[k] <= '0;
      end else if (clock_enable) begin // R6
        if (capture_fire && slot_hit(ptr_reg, k)) begin
          stamp_reg[k] <= counter_reg; // R1
        end else if (is_pwm) begin
          if (k == `ECPU_IDX_PRD && wrap) begin
            stamp_reg[k] <= stamp_reg[`ECPU_IDX_SPRD]; // R11
          end else if (k == `ECPU_IDX_CMP && wrap) begin
            stamp_reg[k] <= stamp_reg[`ECPU_IDX_SCMP]; // R11
          end else if (k == `ECPU_IDX_SPRD && shadow_req.write) begin
            stamp_reg[k] <= shadow_req.period; // R5
          end else if (k == `ECPU_IDX_SCMP && shadow_req.write) begin
            stamp_reg[k] <= shadow_req.compare; // R5
          end
        end
      end
    end
  end

  // ==========================================================
  // pwm output
  // compare wins over wrap so a compare equal to the period gives a steady low
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pwm_reg <= 1'b0;
    end else if (clock_enable) begin
      if (!is_pwm) begin
        pwm_reg <= 1'b0;
      end else if (cmp_hit) begin
        pwm_reg <= 1'b0; // R10
      end else if (wrap) begin
        pwm_reg <= 1'b1; // R10
      end
    end
  end

  // ==========================================================
  // sync output
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sync_out_reg <= 1'b0;
    end else begin
      sync_out_reg <= sync_rise | wrap | overflow; // R7
    end
  end

  // ==========================================================
  // flags and interrupt; a set in the clear cycle wins
  always_comb begin
    flags_set.capture  = capture_fire;
    flags_set.overflow = overflow;
    flags_set.period   = wrap;
    flags_set.compare  = cmp_hit;
    flags_next         = (flags_reg & ~flag_clear) | flags_set; // R8
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      flags_reg <= '0;
      irq_reg   <= 1'b0;
    end else begin
      flags_reg <= flags_next;
      irq_reg   <= |(flags_next & flag_enable); // R8
    end
  end

  // ==========================================================
  // outputs
  assign counter_value             = counter_reg;
  assign period_or_stamp_one       = stamp_reg[`ECPU_IDX_PRD];
  assign compare_or_stamp_two      = stamp_reg[`ECPU_IDX_CMP];
  assign shadow_period_stamp_three = stamp_reg[`ECPU_IDX_SPRD];
  assign shadow_compare_stamp_four = stamp_reg[`ECPU_IDX_SCMP];
  assign auxiliary_pwm_output      = pwm_reg;
  assign counter_sync_out          = sync_out_reg;
  assign channel_interrupt         = irq_reg;
  assign flags_out                 = flags_reg;
  assign mode_out                  = mode_reg;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence wrap_s;
    wrap && !sync_load;
  endsequence

  sequence capture_s;
    capture_fire && clock_enable;
  endsequence

  capture_store_a: assert property ( // R1
    capture_s |=> stamp_reg[$past(ptr_reg)] == $past(counter_reg)
      && ptr_reg == $past(ptr_reg) + `ECPU_PTR_STEP)
    else $error("capture did not store the counter");

  mode_follow_a: assert property ( // R2
    clock_enable ##1 1'b1 |->
      is_pwm == $past(capture_or_pwm_select))
    else $error("mode does not follow select");

  count_up_a: assert property ( // R3
    clock_enable && !sync_load && !wrap |=>
      counter_reg == $past(counter_reg) + CNT_W'(1))
    else $error("counter did not count up");

  shadow_copy_a: assert property ( // R11
    wrap_s |=> counter_reg == '0
      && period_or_stamp_one == $past(shadow_period_stamp_three)
      && compare_or_stamp_two == $past(shadow_compare_stamp_four))
    else $error("wrap did not reload active registers");

  active_hold_a: assert property ( // R11
    is_pwm && clock_enable && !wrap && !capture_fire |=>
      $stable(period_or_stamp_one) && $stable(compare_or_stamp_two))
    else $error("active register changed mid cycle");

  shadow_write_a: assert property ( // R5
    is_pwm && clock_enable && shadow_req.write |=>
      shadow_period_stamp_three == $past(shadow_req.period))
    else $error("shadow period not written");

  pwm_edges_a: assert property ( // R10
    (wrap && !cmp_hit |=> auxiliary_pwm_output) and
    (cmp_hit |=> !auxiliary_pwm_output))
    else $error("pwm edge wrong");

  sync_pair_a: assert property ( // R7
    sync_load |=> counter_reg == $past(sync_phase) ##0 counter_sync_out)
    else $error("sync load or sync out missing");

  freeze_a: assert property ( // R9
    !clock_enable |=> $stable(counter_reg) && $stable(pwm_reg))
    else $error("state moved while clock gated");

  flag_irq_a: assert property ( // R8
    capture_fire |=> flags_out.capture
      ##0 (channel_interrupt == |(flags_out & $past(flag_enable))))
    else $error("flag or interrupt wrong");
endmodule

// ===== dv/ecpu_far_side.sv
module ecpu_far_side (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic fire_event,
  input  wire logic fire_sync,
  output logic      event_in,
  output logic      counter_sync_in
);
  timeunit 1ns;
  timeprecision 100ps;

  logic ev_d;
  logic sy_d;

  // ==========================================================
  // every fire gives a two-cycle high pulse, the narrowest legal one
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ev_d            <= 1'b0;
      sy_d            <= 1'b0;
      event_in        <= 1'b0;
      counter_sync_in <= 1'b0;
    end else begin
      ev_d            <= fire_event;
      sy_d            <= fire_sync;
      event_in        <= fire_event | ev_d;
      counter_sync_in <= fire_sync | sy_d;
    end
  end
endmodule

// ===== dv/test_event_capture_pwm_unit.sv
module test_event_capture_pwm_unit
  import ecpu_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [31:0] PHASE = 32'h0000_0100;

  logic         clk_sys = 1'b0;
  logic         reset = 1'b1;
  logic         clock_enable = 1'b1;
  logic         capture_or_pwm_select = 1'b0;
  logic         fire_event = 1'b0;
  logic         fire_sync = 1'b0;
  logic         sync_load_enable = 1'b1;
  logic [31:0]  sync_phase = PHASE;
  ecpu_shadow_t shadow_req = '0;
  ecpu_flags_t  flag_clear = '0;
  ecpu_flags_t  flag_enable = 4'hF;
  logic         event_in;
  logic         counter_sync_in;
  logic         counter_sync_out;
  logic         auxiliary_pwm_output;
  logic         channel_interrupt;
  logic [31:0]  counter_value;
  logic [31:0]  period_or_stamp_one;
  logic [31:0]  compare_or_stamp_two;
  logic [31:0]  shadow_period_stamp_three;
  logic [31:0]  shadow_compare_stamp_four;
  ecpu_flags_t  flags_out;
  ecpu_mode_t   mode_out;
  int           fail_count = 0;
  int           n_checks = 0;

  always #12.5 clk_sys = ~clk_sys;

  ecpu_far_side far (
    .clk_sys(clk_sys), .reset(reset), .fire_event(fire_event),
    .fire_sync(fire_sync), .event_in(event_in),
    .counter_sync_in(counter_sync_in)
  );

  ecpu_event_capture_channel uut (
    .clk_sys(clk_sys), .reset(reset), .clock_enable(clock_enable),
    .capture_or_pwm_select(capture_or_pwm_select), .event_in(event_in),
    .counter_sync_in(counter_sync_in),
    .sync_load_enable(sync_load_enable),
    .sync_phase(sync_phase), .shadow_req(shadow_req),
    .flag_clear(flag_clear), .flag_enable(flag_enable),
    .counter_value(counter_value),
    .period_or_stamp_one(period_or_stamp_one),
    .compare_or_stamp_two(compare_or_stamp_two),
    .shadow_period_stamp_three(shadow_period_stamp_three),
    .shadow_compare_stamp_four(shadow_compare_stamp_four),
    .auxiliary_pwm_output(auxiliary_pwm_output),
    .counter_sync_out(counter_sync_out),
    .channel_interrupt(channel_interrupt),
    .flags_out(flags_out), .mode_out(mode_out)
  );

  // ==========================================================
  // shared helpers
  task automatic step(int n = 1);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask

  task automatic close_out();
    if (fail_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic wait_reg1(logic [31:0] v);
    for (int i = 0; i < 1000; i++) begin
      step();
      #1;
      if (period_or_stamp_one === v) return;
    end
    $display("[FAIL] wrap wait expected %h seen %h", v, period_or_stamp_one);
    fail_count++;
    close_out();
  endtask

  // counts high then low cycles of one pwm period, bounded at 50 each
  task automatic pwm_shape(int h, int l);
    int n;
    n = 0;
    while (auxiliary_pwm_output === 1'b1 && n < 50) begin
      n++;
      step();
      #1;
    end
    chk("pwm high time", h, n);
    n = 0;
    while (auxiliary_pwm_output === 1'b0 && n < 50) begin
      n++;
      step();
      #1;
    end
    chk("pwm low time", l, n);
  endtask

  // ==========================================================
  // scenarios
  task automatic capture_run();
    step();
    fire_sync <= 1'b1;
    step();
    fire_sync <= 1'b0;
    step();
    #1;
    chk("sync load", PHASE, counter_value);
    chk("sync out", 1, counter_sync_out);
    step(3);
    // five events four cycles apart: the fifth lands in register one
    for (int k = 0; k < 5; k++) begin
      fire_event <= 1'b1;
      step();
      fire_event <= 1'b0;
      step(3);
    end
    #1;
    chk("stamp one", PHASE + 32'h14, period_or_stamp_one);
    chk("stamp two", PHASE + 32'h8, compare_or_stamp_two);
    chk("stamp three", PHASE + 32'hC, shadow_period_stamp_three);
    chk("stamp four", PHASE + 32'h10, shadow_compare_stamp_four);
    chk("irq on capture", 1, channel_interrupt);
    step();
    flag_clear.capture <= 1'b1;
    step();
    flag_clear <= '0;
    step();
    #1;
    chk("flag cleared", 0, flags_out.capture);
    chk("irq cleared", 0, channel_interrupt);
    step();
    flag_enable <= '0;
    fire_event <= 1'b1;
    step();
    fire_event <= 1'b0;
    step(3);
    #1;
    chk("masked flag", 1, flags_out.capture);
    chk("masked irq", 0, channel_interrupt);
  endtask

  task automatic freeze_run();
    logic [31:0] v;
    step();
    clock_enable <= 1'b0;
    step(2);
    #1;
    v = counter_value;
    step(4);
    #1;
    chk("frozen counter", v, counter_value);
    step();
    clock_enable <= 1'b1;
    step(2);
    #1;
    chk("resumed counter", v + 32'h2, counter_value);
  endtask

  task automatic pwm_run();
    step();
    capture_or_pwm_select <= 1'b1;
    step(2);
    shadow_req <= '{write: 1'b1, period: 32'h9, compare: 32'h3};
    step();
    shadow_req.write <= 1'b0;
    wait_reg1(32'h9);
    chk("pwm mode", ECPU_MODE_PWM, mode_out);
    chk("count at wrap", 0, counter_value);
    chk("active compare", 32'h3, compare_or_stamp_two);
    chk("period flag", 1, flags_out.period);
    chk("sync out at wrap", 1, counter_sync_out);
    pwm_shape(4, 6);
    chk("compare flag", 1, flags_out.compare);
    step();
    shadow_req <= '{write: 1'b1, period: 32'h5, compare: 32'h1};
    step();
    shadow_req.write <= 1'b0;
    step();
    #1;
    chk("shadow period", 32'h5, shadow_period_stamp_three);
    chk("period held", 32'h9, period_or_stamp_one);
    wait_reg1(32'h5);
    pwm_shape(2, 4);
    step();
    fire_event <= 1'b1;
    step();
    fire_event <= 1'b0;
    step(3);
    #1;
    chk("capture ignored", 32'h5, period_or_stamp_one);
  endtask

  // sync with loading off, then a load just below the top to reach overflow
  task automatic sync_run();
    step();
    capture_or_pwm_select <= 1'b0;
    sync_load_enable <= 1'b0;
    sync_phase <= 32'hFFFF_FFF0;
    fire_sync <= 1'b1;
    step();
    fire_sync <= 1'b0;
    step();
    #1;
    chk("sync out unloaded", 1, counter_sync_out);
    chk("sync not loaded", 0, counter_value == sync_phase);
    step(2);
    sync_load_enable <= 1'b1;
    fire_sync <= 1'b1;
    step();
    fire_sync <= 1'b0;
    step();
    #1;
    chk("phase loaded", 32'hFFFF_FFF0, counter_value);
    step(16);
    #1;
    chk("overflow flag", 1, flags_out.overflow);
    chk("sync out at overflow", 1, counter_sync_out);
    chk("count rolled over", 0, counter_value);
  endtask

  // the reset values are looked at once a clock edge has applied them
  initial begin
    step(4);
    #1;
    chk("mode in reset", ECPU_MODE_CAPTURE, mode_out);
    chk("irq in reset", 0, channel_interrupt);
    step();
    reset <= 1'b0;
    capture_run();
    freeze_run();
    pwm_run();
    sync_run();
    close_out();
  end
endmodule
